// ### hw/spt_defs.svh
/*
  Constants of the stepper phase translator and chopper: drive sequence, home
  position, timing counts, controller register offsets, fields and reset values.
  Assumes it is included by bare name wherever one of these numbers is needed.
*/
`ifndef SPT_DEFS_SVH
`define SPT_DEFS_SVH

// Master sequence, A,B,C,D from msb to lsb, clockwise order, position 0 is home.
`define SPT_SEQ_0 4'h5
`define SPT_SEQ_1 4'h1
`define SPT_SEQ_2 4'h9
`define SPT_SEQ_3 4'h8
`define SPT_SEQ_4 4'hA
`define SPT_SEQ_5 4'h2
`define SPT_SEQ_6 4'h6
`define SPT_SEQ_7 4'h4
`define SPT_HOME_POS 3'h0

// Timing, each time in ns with its cycle count derived from the clock rate.
`define SPT_CLK_MHZ 100
`define SPT_OSC_HALF_NS 10000
`define SPT_OSC_HALF_CYC ((`SPT_OSC_HALF_NS * `SPT_CLK_MHZ) / 1000)
`define SPT_STEP_HALF_NS 100
`define SPT_STEP_HALF_CYC ((`SPT_STEP_HALF_NS * `SPT_CLK_MHZ) / 1000)

// Controller registers, word index is byte address bits 7:2.
`define SPT_IDX_CTRL 6'h00
`define SPT_IDX_STEP 6'h01
`define SPT_IDX_STATUS 6'h02
`define SPT_CTRL_ENABLE 0
`define SPT_CTRL_DIR 1
`define SPT_CTRL_HALF 2
`define SPT_CTRL_CHOP 3
`define SPT_CTRL_RESET 4
`define SPT_STAT_HOME 0
`define SPT_STAT_BUSY 1
`define SPT_CTRL_RST_VAL 5'h0E

`endif

// ### hw/spt_pkg.sv
/*
  Types of the stepper phase translator and chopper: the state structs of both
  ends and of the chopper channel.
  Assumes spt_defs.svh is on the include path.
*/
package spt_pkg;

  // State of one chopper channel.
  typedef struct packed {
    logic on;
  } spt_chop_state_t;

  // State of the device end.
  typedef struct packed {
    logic [2:0]       pos;
    logic [1:0]       stepSy;
    logic             stepPrev;
    logic [1:0]       dirSy;
    logic [1:0]       sizeSy;
    logic [1:0]       rstSy;
    logic [1:0]       enSy;
    logic [1:0]       ctlSy;
    logic [1:0]       oscSy;
    logic             oscPrev;
    logic [15:0]      oscCnt;
    logic             oscSq;
    logic [1:0][1:0]  tripSy;
    logic [3:0]       phase;
    logic [1:0]       inhN;
  } spt_dev_state_t;

  // State of the controller end.
  typedef struct packed {
    logic [4:0]  ctrl;
    logic [15:0] stepsLeft;
    logic [7:0]  divCnt;
    logic        stepLvl;
    logic [1:0]  homeSy;
    logic        dpValid;
    logic        dpWrite;
    logic [5:0]  dpIdx;
    logic [31:0] rdata;
  } spt_host_state_t;

endpackage

// ### hw/spt_link_if.sv
/*
  Link between the step controller and the translator device.
  Assumes the bench drives oscExt when no device drives the oscillator pin.
*/
`timescale 1ns/1ps
`default_nettype none

interface spt_link_if;
  logic stepClk;
  logic rotationDir;
  logic stepSizeSelect;
  logic resetN;
  logic enable;
  logic chopTargetSelect;
  logic atHomeOe;
  logic atHomeLine;
  logic oscOut;
  logic oscOe;
  logic oscExt;
  logic oscLine;

  // Open collector with pull-up: the line is high while the transistor is off.
  assign atHomeLine = ~atHomeOe;
  // Shared oscillator pin: the driving device wins, else the external source.
  assign oscLine    = oscOe ? oscOut : oscExt;

  modport device (
    input  stepClk,
    input  rotationDir,
    input  stepSizeSelect,
    input  resetN,
    input  enable,
    input  chopTargetSelect,
    output atHomeOe,
    output oscOut,
    output oscOe,
    input  oscLine
  );

  modport host (
    output stepClk,
    output rotationDir,
    output stepSizeSelect,
    output resetN,
    output enable,
    output chopTargetSelect,
    input  atHomeLine
  );
endinterface

`default_nettype wire

// ### hw/spt_chop_channel.sv
/*
  One chopper flip-flop: reset by a sense trip, else set by each oscillator tick.
  Assumes tick is a one-cycle strobe and trip a level, both already in the clk domain.
*/
`timescale 1ns/1ps
`default_nettype none

module spt_chop_channel (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic tick,
  input  wire logic trip,
  output logic      chopOn
);
  import spt_pkg::*;

  spt_chop_state_t s_r;
  spt_chop_state_t s_nxt;

  // A trip wins over a tick, since the current is still above the limit.
  always_comb begin
    s_nxt = s_r;
    if (trip) begin
      s_nxt.on = 1'b0;             // [R13]
    end else if (tick) begin
      s_nxt.on = 1'b1;             // [R13]
    end
  end

  // Enabled after reset so the drive works before the first tick.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r.on <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign chopOn = s_r.on;
endmodule

`default_nettype wire

// ### hw/spt_device.sv
/*
  Translator device end: step counter, phase decode, inhibit logic, two
  choppers on a shared oscillator, home indication and enable gating.
  Assumes every link input and both sense trips come from outside the clk
  domain; the sense trips are digital comparator outputs, active high.
  Assumes the phase and inhibit outputs feed a bridge or darlington stage that
  treats a low inhibit as all four transistors off.
  Assumes the link carries the pull-up of the home line and resolves the
  shared oscillator pin between this end and an outside clock source.
*/
// Behaviour
// R1: 3-bit counter decoded to eight-state sequence.
// R2: Half step walks all eight states.
// R3: Each step edge moves one position, direction-wise.
// R4: Full step skips lsb, which is held.
// R5: Odd start state gives two-phase-on full step.
// R6: Even start state gives wave full step.
// R7: Two-phase-on keeps both inhibit lines high.
// R8: Each inhibit line is the OR of its pair.
// R9: Reset forces home, state 1, ABCD 0101.
// R10: Home output asserted while at home state.
// R11: Enable low forces all six outputs low.
// R12: Two choppers share one oscillator tick.
// R13: Tick sets chopper, trip resets it.
// R14: Target select picks phase or inhibit chopping.
// R15: Phase chop drives the pair's other line high.
// R16: Inhibit chop drives that inhibit line low.
// R17: Oscillator pin drives squarewave or takes clock.
// R18: Home transistor open while home is active.
// R19: Fixed ABCD table for states 1 to 8.
// R20: Advance on step rising edge, sampling modes.
`timescale 1ns/1ps
`default_nettype none
`include "spt_defs.svh"

module spt_device #(
  // One end per link owns the oscillator; OSC_HALF is its half period in clocks.
  parameter logic        OWN_OSC  = 1'b1,
  parameter logic [15:0] OSC_HALF = 16'(`SPT_OSC_HALF_CYC)
) (
  input  wire logic  clk,
  input  wire logic  rstn,
  spt_link_if.device lnk,
  input  wire logic [1:0] senseTrip,
  output logic [3:0] phaseOut,
  output logic       inhibitAbN,
  output logic       inhibitCdN
);
  import spt_pkg::*;

  // All registered state in one struct, and the value it takes at the next edge.
  spt_dev_state_t s_r;
  spt_dev_state_t s_nxt;
  // Strobes derived from the synchronised pins and the oscillator counter, one cycle wide each.
  logic           stepEdge;
  logic           oscTick;
  logic           oscWrap;
  // Chopper flip-flop outputs and the synchronised sense trips per pair.
  logic [1:0]     chopOn;
  logic [1:0]     tripNow;
  // Translator pattern and per-pair scratch values of the output stage.
  logic [3:0]     raw;
  logic           hi;
  logic           lo;
  logic           act;

  // Position to drive pattern; state number is position plus one.
  // Neighbouring entries differ in one line only, so a half step never
  // switches both windings at once; a full step is every second entry.
  function automatic logic [3:0] decode(input logic [2:0] p);
    logic [3:0] v;
    v = `SPT_SEQ_0;
    unique case (p)
      3'h0: v = `SPT_SEQ_0;        // [R19]
      3'h1: v = `SPT_SEQ_1;
      3'h2: v = `SPT_SEQ_2;
      3'h3: v = `SPT_SEQ_3;
      3'h4: v = `SPT_SEQ_4;
      3'h5: v = `SPT_SEQ_5;
      3'h6: v = `SPT_SEQ_6;
      3'h7: v = `SPT_SEQ_7;
    endcase
    return v;
  endfunction

  // Edge detection and the shared-pin tick read only the second synchroniser stage.
  // A step edge is one cycle wide, so a long step pulse moves one position.
  assign stepEdge = s_r.stepSy[1] & ~s_r.stepPrev;                   // [R20]
  assign oscWrap  = (s_r.oscCnt == OSC_HALF - 16'h1);
  // With its own oscillator the tick is the square's rising edge, otherwise
  // the rising edge of the clock taken from the shared pin.
  assign oscTick  = OWN_OSC ? (oscWrap & ~s_r.oscSq)
                            : (s_r.oscSy[1] & ~s_r.oscPrev);         // [R17]
  // Trips are levels, not edges: a held trip keeps its chopper off.
  assign tripNow  = {s_r.tripSy[1][1], s_r.tripSy[0][1]};
  assign raw      = decode(s_r.pos);                                 // [R1]

  // Both channels see the same tick; index 1 is the A/B pair, 0 is C/D.
  // A trip and a tick in one cycle leave the channel off, as the current is still high.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chop
      spt_chop_channel u_chop (
        .clk    (clk),
        .rstn   (rstn),
        .tick   (oscTick),                                           // [R12]
        .trip   (tripNow[gi]),
        .chopOn (chopOn[gi])
      );
    end
  endgenerate

  // Next state: synchronisers, translator, oscillator and output stage.
  always_comb begin
    s_nxt          = s_r;
    hi             = 1'b0;
    lo             = 1'b0;
    act            = 1'b0;

    // Every pin passes two stages before any logic reads it; the cost is
    // two cycles of latency on every input, well below a step period.
    s_nxt.stepSy   = {s_r.stepSy[0], lnk.stepClk};
    s_nxt.stepPrev = s_r.stepSy[1];
    s_nxt.dirSy    = {s_r.dirSy[0], lnk.rotationDir};
    s_nxt.sizeSy   = {s_r.sizeSy[0], lnk.stepSizeSelect};
    s_nxt.rstSy    = {s_r.rstSy[0], lnk.resetN};
    s_nxt.enSy     = {s_r.enSy[0], lnk.enable};
    s_nxt.ctlSy    = {s_r.ctlSy[0], lnk.chopTargetSelect};
    s_nxt.oscSy    = {s_r.oscSy[0], lnk.oscLine};
    s_nxt.oscPrev  = s_r.oscSy[1];
    // Sense trips come from analog comparators and are synchronised too.
    s_nxt.tripSy[0] = {s_r.tripSy[0][0], senseTrip[0]};
    s_nxt.tripSy[1] = {s_r.tripSy[1][0], senseTrip[1]};

    // Direction and step size travel through the same two stages as the
    // step clock, so they are sampled at the very edge they came with.
    // The link reset is synchronised like the other pins, so home is
    // reached three cycles after it falls and held for as long as it is low.
    if (!s_r.rstSy[1]) begin
      s_nxt.pos = `SPT_HOME_POS;                                     // [R9]
    end else if (stepEdge) begin
      if (s_r.sizeSy[1]) begin
        // Half step walks every master state.
        s_nxt.pos = s_r.dirSy[1] ? s_r.pos + 3'h1 : s_r.pos - 3'h1;  // [R2] [R3]
      end else begin
        // Full step bypasses the lsb; it keeps its value, so an even
        // position (odd state) stays two-phase-on and an odd position
        // (even state) stays wave drive.
        s_nxt.pos = {s_r.dirSy[1] ? s_r.pos[2:1] + 2'h1
                                  : s_r.pos[2:1] - 2'h1, s_r.pos[0]}; // [R4] [R5] [R6]
      end
    end

    // Free-running squarewave, only driven out with its own oscillator.
    // Without its own oscillator the counter still runs but nothing reads
    // its square, so a slave end takes every tick from the shared pin.
    if (oscWrap) begin
      s_nxt.oscCnt = 16'h0;
      s_nxt.oscSq  = ~s_r.oscSq;
    end else begin
      s_nxt.oscCnt = s_r.oscCnt + 16'h1;
    end

    // Output stage per pair; i is the pair index as for the choppers.
    for (int i = 0; i < 2; i++) begin
      hi  = raw[2*i+1];
      lo  = raw[2*i];
      act = hi | lo;                                                 // [R8] [R7]
      if (s_r.ctlSy[1]) begin
        // Phase chopping pulls the idle line up, so the decay current
        // recirculates in the upper half and bypasses the sense resistor.
        s_nxt.phase[2*i+1] = hi | (~chopOn[i] & act);               // [R14] [R15]
        s_nxt.phase[2*i]   = lo | (~chopOn[i] & act);               // [R15]
        s_nxt.inhN[i]      = act;
      end else begin
        // Inhibit chopping switches off the whole bridge half, so the
        // current decays into the supply at full speed.
        s_nxt.phase[2*i+1] = hi;
        s_nxt.phase[2*i]   = lo;
        s_nxt.inhN[i]      = act & chopOn[i];                        // [R14] [R16]
      end
    end
    // Enable low wins over translator and choppers, keeping the power stage
    // off while the system starts up.
    if (!s_r.enSy[1]) begin
      s_nxt.phase = 4'h0;                                            // [R11]
      s_nxt.inhN  = 2'h0;                                            // [R11]
    end
  end

  // Outputs come up disabled, matching enable low during reset.
  // The translator starts at home, so the home line is released at once.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '{pos: `SPT_HOME_POS, oscCnt: 16'h0, phase: 4'h0, inhN: 2'h0, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Home line conducts (pulled low) whenever the translator is not home.
  assign lnk.atHomeOe = (s_r.pos != `SPT_HOME_POS);                  // [R10] [R18]
  // A slave end never drives the shared pin, so only one end owns it.
  assign lnk.oscOut   = s_r.oscSq;                                   // [R17]
  assign lnk.oscOe    = OWN_OSC;                                     // [R17]
  // Drive lines straight from flip-flops, so the power stage sees no glitch.
  assign phaseOut     = s_r.phase;
  assign inhibitAbN   = s_r.inhN[1];
  assign inhibitCdN   = s_r.inhN[0];
endmodule

`default_nettype wire

// ### hw/spt_host.sv
/*
  Step controller end: an AHB-Lite slave holding control, step count and
  status, and the step clock generator that drives the link.
  Assumes a single AHB-Lite master doing single word transfers.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spt_defs.svh"

module spt_host #(
  parameter logic [7:0] STEP_HALF = 8'(`SPT_STEP_HALF_CYC)
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  spt_link_if.host         lnk
);
  import spt_pkg::*;

  spt_host_state_t s_r;
  spt_host_state_t s_nxt;
  logic            addrPhase;

  // Only word transfers are used, so hsize is not decoded.
  assign addrPhase = hsel & htrans[1] & hready;

  // Next state: step generator first, then a register write overrides it.
  always_comb begin
    s_nxt        = s_r;
    s_nxt.homeSy = {s_r.homeSy[0], lnk.atHomeLine};

    // One step is a low half then a high half; the count drops at the fall.
    if (s_r.stepsLeft != 16'h0) begin
      if (s_r.divCnt == STEP_HALF - 8'h1) begin
        s_nxt.divCnt  = 8'h0;
        s_nxt.stepLvl = ~s_r.stepLvl;                               // [R3]
        if (s_r.stepLvl) begin
          s_nxt.stepsLeft = s_r.stepsLeft - 16'h1;
        end
      end else begin
        s_nxt.divCnt = s_r.divCnt + 8'h1;
      end
    end

    if (s_r.dpValid && s_r.dpWrite) begin
      if (s_r.dpIdx == `SPT_IDX_CTRL) begin
        s_nxt.ctrl = hwdata[4:0];
      end else if (s_r.dpIdx == `SPT_IDX_STEP) begin
        s_nxt.stepsLeft = hwdata[15:0];
        s_nxt.divCnt    = 8'h0;
      end
    end

    s_nxt.dpValid = addrPhase;
    s_nxt.dpWrite = hwrite;
    s_nxt.dpIdx   = haddr[7:2];
    // Control and step reads reflect any write finishing in this same cycle.
    if (addrPhase && !hwrite) begin
      if (haddr[7:2] == `SPT_IDX_CTRL) begin
        s_nxt.rdata = {27'h0, s_nxt.ctrl};
      end else if (haddr[7:2] == `SPT_IDX_STEP) begin
        s_nxt.rdata = {16'h0, s_nxt.stepsLeft};
      end else if (haddr[7:2] == `SPT_IDX_STATUS) begin
        s_nxt.rdata = {30'h0, s_r.stepsLeft != 16'h0, s_r.homeSy[1]};
      end else begin
        s_nxt.rdata = 32'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '{ctrl: `SPT_CTRL_RST_VAL, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Zero wait state slave, always OKAY.
  assign hreadyout            = 1'b1;
  assign hresp                = 1'b0;
  assign hrdata               = s_r.rdata;
  assign lnk.stepClk          = s_r.stepLvl;
  assign lnk.enable           = s_r.ctrl[`SPT_CTRL_ENABLE];
  assign lnk.rotationDir      = s_r.ctrl[`SPT_CTRL_DIR];
  assign lnk.stepSizeSelect   = s_r.ctrl[`SPT_CTRL_HALF];
  assign lnk.chopTargetSelect = s_r.ctrl[`SPT_CTRL_CHOP];
  assign lnk.resetN           = ~s_r.ctrl[`SPT_CTRL_RESET];          // [R9]
endmodule

`default_nettype wire

// ### test/spt_link_asserts.sv
/*
  Concurrent checks on the step link between the controller and the translator device.
  Assumes the bench instantiates it beside the link, fed with the bench's clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none

module spt_link_asserts #(
  parameter int OSC_HALF = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic stepClk,
  input wire logic rotationDir,
  input wire logic stepSizeSelect,
  input wire logic resetN,
  input wire logic atHomeOe,
  input wire logic atHomeLine,
  input wire logic oscOut,
  input wire logic oscOe,
  input wire logic oscLine
);
  logic [15:0] oscCnt_r;
  logic        oscPrev_r;
  logic        oscSeen_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Cycles since the last oscillator edge; the first edge after reset has no reference, so it is not timed.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      oscCnt_r  <= 16'h0000;
      oscPrev_r <= 1'b0;
      oscSeen_r <= 1'b0;
    end else begin
      oscPrev_r <= oscOut;
      oscCnt_r  <= (oscOut != oscPrev_r) ? 16'h0001 : oscCnt_r + 16'h0001;
      oscSeen_r <= oscSeen_r | (oscOut != oscPrev_r);
    end
  end

  property p_home_reset;
    !resetN [*5] |-> !atHomeOe;
  endproperty
  a_home_reset: assert property (p_home_reset) else $error("link reset did not reach home");

  property p_home_line;
    atHomeLine == !atHomeOe;
  endproperty
  a_home_line: assert property (p_home_line) else $error("home line polarity wrong");

  property p_osc_drive;
    oscOe && (oscLine == oscOut);
  endproperty
  a_osc_drive: assert property (p_osc_drive) else $error("oscillator pin not driven");

  property p_osc_half;
    (oscOut != oscPrev_r) && oscSeen_r |-> oscCnt_r == OSC_HALF;
  endproperty
  a_osc_half: assert property (p_osc_half) else $error("oscillator half period wrong");

  property p_step_high;
    $rose(stepClk) |-> stepClk [*4] ##1 !stepClk;
  endproperty
  a_step_high: assert property (p_step_high) else $error("step pulse width wrong");

  property p_step_low;
    $fell(stepClk) |-> !stepClk [*4];
  endproperty
  a_step_low: assert property (p_step_low) else $error("step low time too short");

  property p_leave_home;
    $rose(stepClk) && !atHomeOe && resetN |-> ##[3:4] atHomeOe;
  endproperty
  a_leave_home: assert property (p_leave_home) else $error("step did not leave home");

  property p_home_cause;
    $rose(atHomeOe) |-> $past(stepClk, 3) || $past(stepClk, 4);
  endproperty
  a_home_cause: assert property (p_home_cause) else $error("home left without a step");

  property p_mode_hold;
    stepClk |-> $stable(rotationDir) && $stable(stepSizeSelect);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed during step");

  c_step: cover property ($rose(stepClk));
  c_reset: cover property (!resetN [*5]);
  c_leave: cover property ($rose(atHomeOe));
endmodule

`default_nettype wire

// ### test/test_stepper_phase_translator_chopper.sv
/*
  Self-checking bench: controller and translator joined by the link, driven over AHB-Lite.
  Assumes the design files and spt_defs.svh are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spt_defs.svh"

module test_stepper_phase_translator_chopper;
  typedef struct packed {
    logic [4:0]  ctrl;
    logic [15:0] steps;
    logic [2:0]  pos;
  } spt_row_t;

  localparam logic [31:0] ACTRL = {24'h0, `SPT_IDX_CTRL, 2'h0};
  localparam logic [31:0] ASTEP = {24'h0, `SPT_IDX_STEP, 2'h0};
  localparam logic [31:0] ASTAT = {24'h0, `SPT_IDX_STATUS, 2'h0};

  logic        clk;
  logic        rstn;
  logic        hsel;
  logic        hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [1:0]  senseTrip;
  logic [3:0]  phaseOut;
  logic        inhibitAbN;
  logic        inhibitCdN;
  int          failures;
  int          checks;
  logic [3:0]  seqTab [8] = '{`SPT_SEQ_0, `SPT_SEQ_1, `SPT_SEQ_2, `SPT_SEQ_3,
                              `SPT_SEQ_4, `SPT_SEQ_5, `SPT_SEQ_6, `SPT_SEQ_7};
  // Rows run in order from home: control word, step count, expected position.
  spt_row_t    rows [8] = '{'{5'h07, 16'h0001, 3'h1}, '{5'h07, 16'h0002, 3'h3},
                            '{5'h03, 16'h0001, 3'h5}, '{5'h01, 16'h0003, 3'h7},
                            '{5'h07, 16'h0001, 3'h0}, '{5'h03, 16'h0002, 3'h4},
                            '{5'h01, 16'h0004, 3'h4}, '{5'h05, 16'h0002, 3'h2}};

  spt_link_if spt_link_if_i ();

  spt_host #(.STEP_HALF(8'h04)) spt_host_i (
    .clk      (clk),
    .rstn     (rstn),
    .hsel     (hsel),
    .haddr    (haddr),
    .htrans   (htrans),
    .hwrite   (hwrite),
    .hsize    (hsize),
    .hwdata   (hwdata),
    .hready   (hreadyout),
    .hreadyout(hreadyout),
    .hresp    (hresp),
    .hrdata   (hrdata),
    .lnk      (spt_link_if_i)
  );

  spt_device #(.OSC_HALF(16'h0008)) spt_device_i (
    .clk       (clk),
    .rstn      (rstn),
    .lnk       (spt_link_if_i),
    .senseTrip (senseTrip),
    .phaseOut  (phaseOut),
    .inhibitAbN(inhibitAbN),
    .inhibitCdN(inhibitCdN)
  );

  spt_link_asserts #(.OSC_HALF(8)) spt_link_asserts_i (
    .clk           (clk),
    .rstn          (rstn),
    .stepClk       (spt_link_if_i.stepClk),
    .rotationDir   (spt_link_if_i.rotationDir),
    .stepSizeSelect(spt_link_if_i.stepSizeSelect),
    .resetN        (spt_link_if_i.resetN),
    .atHomeOe      (spt_link_if_i.atHomeOe),
    .atHomeLine    (spt_link_if_i.atHomeLine),
    .oscOut        (spt_link_if_i.oscOut),
    .oscOe         (spt_link_if_i.oscOe),
    .oscLine       (spt_link_if_i.oscLine)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // One single-word transfer; data is taken once the data phase has been accepted.
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    #1;
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask

  // Settles one time unit past the edge so outputs are read after they land.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_idle();
    logic [31:0] s;
    s = 32'h2;
    for (int n = 0; n < 400 && s[`SPT_STAT_BUSY]; n++) bus(ASTAT, 1'b0, 32'h0, s);
    chk(32'(s[`SPT_STAT_BUSY]), 32'h0);
    repeat (12) @(posedge clk);
  endtask

  task automatic check_pos(input logic [2:0] pos);
    logic [31:0] s;
    bus(ASTAT, 1'b0, 32'h0, s);
    chk(32'(phaseOut), 32'(seqTab[pos]));
    chk(32'({inhibitAbN, inhibitCdN}), 32'({|seqTab[pos][3:2], |seqTab[pos][1:0]}));
    chk(32'(s[`SPT_STAT_HOME]), 32'(pos == 3'h0));
  endtask

  task automatic do_reset();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
  endtask

  task automatic wrap_up();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // A hang ends the run as a failure well after the tests should be over.
  initial begin
    repeat (50000) @(posedge clk);
    failures++;
    wrap_up();
  end

  // Main sequence: reset values, the row table, then chopper, link reset and a second reset.
  initial begin
    logic [31:0] d;
    rstn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    senseTrip = 2'h0;
    spt_link_if_i.oscExt = 1'b0;
    failures = 0;
    checks = 0;
    do_reset();
    bus(ACTRL, 1'b0, 32'h0, d);
    chk(d, 32'(`SPT_CTRL_RST_VAL));
    chk(32'({phaseOut, inhibitAbN, inhibitCdN}), 32'h0);
    chk(32'(spt_link_if_i.atHomeLine), 32'h1);
    chk(32'(hresp), 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(ACTRL, 32'(rows[i].ctrl));
      wr(ASTEP, 32'(rows[i].steps));
      wait_idle();
      check_pos(rows[i].pos);
    end
    $display("table test done");
    wr(ACTRL, 32'h0000000F);
    @(posedge clk) senseTrip <= 2'b10;
    cyc(8);
    chk(32'({phaseOut, inhibitAbN}), 32'h1B);
    @(posedge clk) senseTrip <= 2'b01;
    cyc(8);
    chk(32'(phaseOut[1:0]), 32'h3);
    @(posedge clk) senseTrip <= 2'b00;
    cyc(30);
    chk(32'(phaseOut), 32'h9);
    wr(ACTRL, 32'h00000007);
    @(posedge clk) senseTrip <= 2'b10;
    cyc(8);
    chk(32'({inhibitAbN, inhibitCdN, phaseOut}), 32'h19);
    @(posedge clk) senseTrip <= 2'b11;
    wr(ACTRL, 32'h00000006);
    cyc(8);
    chk(32'({phaseOut, inhibitAbN, inhibitCdN}), 32'h0);
    @(posedge clk) senseTrip <= 2'b00;
    $display("chopper test done");
    wr(ACTRL, 32'h00000017);
    cyc(24);
    check_pos(3'h0);
    wr(ASTEP, 32'h00000002);
    wait_idle();
    check_pos(3'h0);
    wr(ACTRL, 32'h00000007);
    wr(32'h0000000C, 32'hFFFFFFFF);
    bus(32'h0000000C, 1'b0, 32'h0, d);
    chk(d, 32'h0);
    $display("link reset test done");
    do_reset();
    bus(ACTRL, 1'b0, 32'h0, d);
    chk(d, 32'(`SPT_CTRL_RST_VAL));
    chk(32'({phaseOut, inhibitAbN, inhibitCdN}), 32'h0);
    $display("second reset test done");
    wrap_up();
  end
endmodule

`default_nettype wire
